/* dv/tb_trt_timer.sv */
// Self-checking bench for trt_timer against a behavioural PCI target.
// Assumes the checker is bound by its own file; inputs move on falling edges.
`timescale 1ns/1ps
module tb_trt_timer;
   logic       clk = 1'b0, rst_n = 1'b0, frame_n = 1'b1, irdy_n = 1'b1, rty = 1'b0;
   logic       trdy_n, stop_n, abort, serr;
   logic [4:0] set = 5'h00;
   logic [7:0] wt = 8'h00, cnt;
   int         exp_q[$];
   int         seed = 74988, bad_count = 0, tests_run = 0, cyc = 0;
   always #2.5 clk = ~clk;
   trt_timer trt_timer_inst (.i_ref_clk(clk), .i_rst_n(rst_n), .i_timer_set(set),
      .i_frame_n(frame_n), .i_irdy_n(irdy_n), .i_trdy_n(trdy_n), .i_stop_n(stop_n),
      .o_master_abort(abort), .o_serr(serr), .o_count(cnt));
   trt_target_model trt_target_model_inst (.i_ref_clk(clk), .i_frame_n(frame_n),
      .i_irdy_n(irdy_n), .i_wait(wt), .i_retry(rty), .o_trdy_n(trdy_n), .o_stop_n(stop_n));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_cyc(input int got, input int exp);
      tests_run++;
      if (got != exp)
      begin
         bad_count++;
         $display("[FAIL] %0t abort at cycle %0d expected %0d", $time, got, exp);
      end
   endtask : chk_cyc
   task automatic conclude();
      $display("tests_run %0d bad_count %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude
   // Mode 0 slow target, 1 fast target, 2 endless retry with a bus gap, 3 timer off
   task automatic run(input int m);
      int s;
      s = (m == 3) ? 0 : 1 + {$random(seed)} % 4;
      set <= 5'(s);
      wt <= (m == 1) ? 8'(8 * s - 3) : 8'hff;
      rty <= (m == 2);
      repeat (4) @(negedge clk);
      frame_n <= 1'b0;
      irdy_n <= 1'b0;
      // Abort due 8s+10 cycles on; two idle cycles in a retry add three
      if (m == 0) exp_q.push_back(cyc + 8 * s + 10);
      if (m == 2) exp_q.push_back(cyc + 8 * s + 13);
      repeat (8) @(negedge clk);
      if (m == 2)
      begin
         frame_n <= 1'b1;
         irdy_n <= 1'b1;
         repeat (2) @(negedge clk);
         frame_n <= 1'b0;
         irdy_n <= 1'b0;
      end
      repeat (8 * s + 32) @(negedge clk);
      frame_n <= 1'b1;
      irdy_n <= 1'b1;
      repeat (10) @(negedge clk);
      chk(8'(exp_q.size()), 8'h00);
   endtask : run
   // Results taken at falling edges, once the registers have settled
   always @(negedge clk)
      if (abort === 1'b1)
      begin
         chk({7'h00, serr}, 8'h01);
         chk(cnt, 8'h00);
         if (exp_q.size() == 0) chk(8'h01, 8'h00);
         else chk_cyc(cyc, exp_q.pop_front());
      end
   // Hang guard, well above twelve transactions of at most 90 cycles
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         bad_count++;
         conclude();
      end
   end
   initial
   begin
      repeat (20) @(negedge clk);
      rst_n <= 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 12; i++) run(i % 4);
      conclude();
   end
endmodule : tb_trt_timer

/* dv/trt_target_model.sv */
// Behavioural PCI target: answers after a set wait, or retries forever.
// Assumes the master drives FRAME#/IRDY#; released pins sit on pull-ups.
`timescale 1ns/1ps
module trt_target_model
(
   // Clock and master pins
   input  wire logic       i_ref_clk,
   input  wire logic       i_frame_n,
   input  wire logic       i_irdy_n,
   // Behaviour chosen by the bench
   input  wire logic [7:0] i_wait,
   input  wire logic       i_retry,
   // Target pins
   output logic            o_trdy_n = 1'b1,
   output logic            o_stop_n = 1'b1
);
   logic [7:0] wait_q = 8'h00;
   // One ready per i_wait+1 cycles; idle bus lets both pins float high
   always @(negedge i_ref_clk)
   begin
      wait_q <= (i_frame_n && i_irdy_n || wait_q == i_wait) ? 8'h00 : wait_q + 8'h01;
      o_trdy_n <= i_frame_n && i_irdy_n || i_retry || wait_q != i_wait;
      o_stop_n <= i_frame_n && i_irdy_n || !i_retry;
   end
endmodule : trt_target_model

/* dv/trt_timer_checker.sv */
// Assertions on the ports of the target response timer.
// Assumes one clock domain; bus pins reach the logic two edges late.
`timescale 1ns/1ps
module trt_timer_checker
(
   // Clock and reset
   input wire logic       i_ref_clk,
   input wire logic       i_rst_n,
   // Watched ports
   input wire logic [4:0] i_timer_set,
   input wire logic       i_frame_n,
   input wire logic       i_irdy_n,
   input wire logic       i_trdy_n,
   input wire logic       i_stop_n,
   input wire logic       o_master_abort,
   input wire logic       o_serr,
   input wire logic [7:0] o_count
);
   // Retried cycle still pending on the pins; its count carries on
   logic rty_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rty_q <= 1'b0;
      else if (!i_irdy_n && !i_trdy_n || o_master_abort)
         rty_q <= 1'b0;
      else if (!i_stop_n && i_trdy_n)
         rty_q <= 1'b1;
   end
   // ----
   // Pin samples are taken two to four edges back to cover the synchroniser
   // ----
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   AST_OFF: assert property (~|i_timer_set && ~|$past(i_timer_set) |-> !o_master_abort)
      else $error("abort while off");
   AST_LOAD: assert property ($past(i_frame_n && i_irdy_n, 4) && !$past(i_frame_n, 3)
      && !rty_q && $stable(i_timer_set) |-> o_count == {i_timer_set, 3'h7})
      else $error("bad start");
   AST_RELOAD: assert property ($past(!i_irdy_n && !i_trdy_n, 3) && |i_timer_set
      && $stable(i_timer_set) |-> o_count == {i_timer_set, 3'h7}) else $error("no reload");
   AST_ABORT: assert property (o_master_abort |-> o_serr && o_count == 8'h00
      && $past(o_count) == 8'h01) else $error("bad abort");
   AST_RETRY: assert property ($past(!i_stop_n && i_trdy_n, 2) && o_count == 8'h01
      && |i_timer_set |=> o_master_abort && o_serr) else $error("retry not ended");
   AST_DEC: assert property (!$past(i_frame_n, 3) && !$past(i_frame_n, 4)
      && $past(i_trdy_n, 3) && |i_timer_set && $past(o_count) > 8'h01
      |-> o_count == $past(o_count) - 8'h01) else $error("no count down");
endmodule : trt_timer_checker

bind trt_timer trt_timer_checker trt_timer_checker_inst (.*);

/* rtl/trt_pkg.sv */
// Package for the target response timer: widths, constants, carriers.
// Assumes a single reference clock shared by the master and the timer.
package trt_pkg;

   // ----------------------------------------------------------------------
   // Widths and constants
   // ----------------------------------------------------------------------
   localparam int          TRT_SET_W    = 5;
   localparam int          TRT_CNT_W    = 8;
   localparam int          TRT_LOW_W    = TRT_CNT_W - TRT_SET_W;
   localparam logic [4:0]  TRT_SET_OFF  = 5'h00;
   localparam logic [2:0]  TRT_LOW_FILL = 3'h7;
   localparam logic [7:0]  TRT_CNT_ZERO = 8'h00;
   localparam logic [7:0]  TRT_CNT_ONE  = 8'h01;
   localparam logic        TRT_PIN_IDLE = 1'b1;

   // ----------------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------------
   // Bus events seen by the master, sampled from synchronised pins
   typedef struct packed {
      logic active;     // Master transaction in progress
      logic data_done;  // Data phase completed (IRDY# and TRDY# low)
      logic retry;      // Target signalled retry
   } trt_bus_ev_t;

   // Results handed back to the master sequencer
   typedef struct packed {
      logic abort;      // End cycle with master abort
      logic serr;       // Flag system error
   } trt_result_t;

   typedef enum logic [1:0] {
      TRT_IDLE  = 2'b00,
      TRT_WAIT  = 2'b01,
      TRT_ABORT = 2'b10
   } trt_state_t;

endpackage : trt_pkg

/* rtl/trt_sync2.sv */
// Two-stage synchroniser for one level from outside the clock domain.
// Assumes the input is a plain level; first stage is read only by the second.
`timescale 1ns/1ps
module trt_sync2
#(
   // Level shown while reset is held
   parameter logic RST_VAL = 1'b0
)
(
   // Clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   // Level in and out
   input  wire logic i_level,
   output logic      o_level
);

   logic meta_q;
   logic meta_d;
   logic sync_q;
   logic sync_d;

   // ----------------------------------------------------------------------
   // Next values
   // ----------------------------------------------------------------------
   always_comb
   begin
      meta_d = i_level;
      sync_d = meta_q;
   end

   // Registers only
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end
      else
      begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign o_level = sync_q;

endmodule : trt_sync2

/* rtl/trt_timer.sv */
// Overview of operation
// - Zero setting disables all timeout aborts.
// - Setting forms upper five bits of counter.
// - Reload counter on every completed data phase outside the abort state.
// - Expiry before TRDY# aborts and flags SERR#.
// - Endless retries also end in master abort.
//
// Target response watchdog for the PCI master.
// Assumes the bus pins are active low and asynchronous to i_ref_clk;
// the timer setting comes from master configuration logic on this clock.
//
// Pins are synchronised raw and inverted after the second stage, so
// reset shows an idle bus and no false transaction follows it.
// The synchronisers cost two cycles of latency on every pin; the
// timeout therefore runs two cycles behind the bus, which is
// negligible against the shortest programmed count.
// A retried cycle keeps its count across the idle gap between
// retries, so a target that only ever retries still runs out.
`timescale 1ns/1ps
module trt_timer
(
   // Clock and reset
   input  wire logic                            i_ref_clk,
   input  wire logic                            i_rst_n,
   // Configuration from the master
   input  wire logic [trt_pkg::TRT_SET_W-1:0]   i_timer_set,
   // Bus pins observed (active low)
   input  wire logic                            i_frame_n,
   input  wire logic                            i_irdy_n,
   input  wire logic                            i_trdy_n,
   input  wire logic                            i_stop_n,
   // Results to the master sequencer
   output logic                                 o_master_abort,
   output logic                                 o_serr,
   output logic [trt_pkg::TRT_CNT_W-1:0]        o_count
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic frame_n_s;
   logic irdy_n_s;
   logic trdy_n_s;
   logic stop_n_s;
   logic frame_s;
   logic irdy_s;
   logic trdy_s;
   logic stop_s;

   // FRAME# level into the clock domain
   trt_sync2
   #(
      .RST_VAL   (trt_pkg::TRT_PIN_IDLE)
   )
   u_sync_frame
   (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_level   (i_frame_n),
      .o_level   (frame_n_s)
   );

   // IRDY# level into the clock domain
   trt_sync2
   #(
      .RST_VAL   (trt_pkg::TRT_PIN_IDLE)
   )
   u_sync_irdy
   (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_level   (i_irdy_n),
      .o_level   (irdy_n_s)
   );

   // TRDY# level into the clock domain
   trt_sync2
   #(
      .RST_VAL   (trt_pkg::TRT_PIN_IDLE)
   )
   u_sync_trdy
   (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_level   (i_trdy_n),
      .o_level   (trdy_n_s)
   );

   // STOP# level into the clock domain
   trt_sync2
   #(
      .RST_VAL   (trt_pkg::TRT_PIN_IDLE)
   )
   u_sync_stop
   (
      .i_ref_clk (i_ref_clk),
      .i_rst_n   (i_rst_n),
      .i_level   (i_stop_n),
      .o_level   (stop_n_s)
   );

   // Active-high levels, taken only after the second stage
   assign frame_s = ~frame_n_s;
   assign irdy_s  = ~irdy_n_s;
   assign trdy_s  = ~trdy_n_s;
   assign stop_s  = ~stop_n_s;

   // ----------------------------------------------------------------------
   // Bus event decode
   // ----------------------------------------------------------------------
   trt_pkg::trt_bus_ev_t ev;
   logic                 enabled;
   logic [trt_pkg::TRT_CNT_W-1:0] start_val;

   // Retry is STOP# without TRDY#; a done phase needs both ready lines
   always_comb
   begin
      ev.active    = frame_s | irdy_s;
      ev.data_done = irdy_s & trdy_s;
      ev.retry     = stop_s & ~trdy_s;
   end

   assign enabled   = (i_timer_set != trt_pkg::TRT_SET_OFF);
   assign start_val = {i_timer_set, trt_pkg::TRT_LOW_FILL};

   // ----------------------------------------------------------------------
   // Counter and state
   // ----------------------------------------------------------------------
   trt_pkg::trt_state_t            state_q;
   trt_pkg::trt_state_t            state_d;
   logic [trt_pkg::TRT_CNT_W-1:0]  cnt_q;
   logic [trt_pkg::TRT_CNT_W-1:0]  cnt_d;
   trt_pkg::trt_result_t           res_q;
   trt_pkg::trt_result_t           res_d;
   logic                           retry_q;
   logic                           retry_d;

   // Retries do not reload, so a target retrying forever still expires
   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      res_d   = '0;
      retry_d = retry_q;
      case (state_q)
         trt_pkg::TRT_IDLE:
         begin
            // A retried cycle keeps its count across the idle gap
            if (retry_q && !ev.data_done)
            begin
               cnt_d = cnt_q;
            end
            else
            begin
               cnt_d   = start_val;
               retry_d = 1'b0;
            end
            // Switching the timer off forgets any pending retry
            if (!enabled)
            begin
               retry_d = 1'b0;
            end
            if (ev.active && enabled)
               state_d = trt_pkg::TRT_WAIT;
         end
         trt_pkg::TRT_WAIT:
         begin
            if (!enabled)
            begin
               state_d = trt_pkg::TRT_IDLE;
               retry_d = 1'b0;
            end
            else if (ev.data_done)
            begin
               cnt_d = start_val;
               retry_d = 1'b0;
               if (!ev.active)
                  state_d = trt_pkg::TRT_IDLE;
            end
            else if (!ev.active)
            begin
               state_d = trt_pkg::TRT_IDLE;
            end
            else if (cnt_q <= trt_pkg::TRT_CNT_ONE)
            begin
               cnt_d     = trt_pkg::TRT_CNT_ZERO;
               res_d.abort = 1'b1;
               res_d.serr  = 1'b1;
               state_d   = trt_pkg::TRT_ABORT;
               retry_d   = 1'b0;
            end
            else
            begin
               cnt_d = cnt_q - trt_pkg::TRT_CNT_ONE;
               if (ev.retry)
                  retry_d = 1'b1;
            end
         end
         trt_pkg::TRT_ABORT:
         begin
            // Hold until the bus goes idle so the abort is reported once
            if (!ev.active)
               state_d = trt_pkg::TRT_IDLE;
         end
         default:
         begin
            state_d = trt_pkg::TRT_IDLE;
            retry_d = 1'b0;
         end
      endcase
   end

   // Registers only
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_q <= trt_pkg::TRT_IDLE;
         cnt_q   <= trt_pkg::TRT_CNT_ZERO;
         res_q   <= '0;
         retry_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         res_q   <= res_d;
         retry_q <= retry_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign o_master_abort = res_q.abort;
   assign o_serr         = res_q.serr;
   assign o_count        = cnt_q;

endmodule : trt_timer
